// ==== src/hdlc_transmit_packet_processor.sv ====
// Purpose: hdlc transmit packet processor with apb registers
// Assumes: framer pulses i_bit_req once per overhead bit slot
// Notes: registers answer with no wait state
// Contract
// - storage available when free exceeds threshold times eight
// - packet start disable stops after current packet
// - fcs inverted crc, error insert sends plain
// - fill with flags or all ones
// - bytes leave lsb first unless reordered
// - optional inversion of every outgoing bit
// - fcs appended unless fcs disabled
// - fifo reset empties, halts, powers down, drops
// - after fifo reset wait ram power-up
// - five registers on even offsets, three unused
// - upper byte write loads byte and end
// - status shows free groups, full, empty, available
// - latched empty, available set on rise, reset release
//
// The APB interface to the registers was decided locally.
module hdlc_transmit_packet_processor (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// apb slave
	input wire hdlc_tx_pkg::apb_req_t i_apb,
	output hdlc_tx_pkg::apb_rsp_t o_apb,
	// serial stream to the overhead channel
	input wire logic i_bit_req,
	output logic o_tx_bit,
	// ram power and interrupt
	output logic o_ram_power_down,
	output logic o_irq
);
	import hdlc_tx_pkg::*;

	typedef enum logic [2:0] {
		ST_FILL = 3'b000,
		ST_OPEN = 3'b001,
		ST_DATA = 3'b010,
		ST_FCS0 = 3'b011,
		ST_FCS1 = 3'b100,
		ST_CLOSE = 3'b101
	} tx_state_t;

	ctrl_t ctrl;
	logic [5:0] lat;
	logic [5:0] ie;
	logic [31:0] rdata;
	logic [3:0] pwr_cnt;
	logic empty_q;
	logic avail_q;
	logic frst_q;
	tx_state_t state;
	tx_state_t next_state;
	logic [7:0] shift;
	logic [7:0] next_byte;
	logic [2:0] bitcnt;
	logic [2:0] ones;
	logic [15:0] crc;
	logic [15:0] crc_step;
	logic [7:0] fcs_hi;
	logic cur_last;
	logic tx_bit;
	logic pop_sel;
	logic under_sel;
	fifo_entry_t fifo_rd;
	logic fifo_empty;
	logic fifo_full;
	logic [8:0] free_bytes;
	logic [7:0] rev_byte;

	// address decode; unused words of the window read zero
	wire logic [7:0] idx = i_apb.paddr[9:2];
	wire logic setup = i_apb.psel && !i_apb.penable;
	// upper address bits must be zero, or the window would alias
	wire logic hi_zero = (i_apb.paddr[11:10] == 2'b00);
	wire logic hit = hi_zero && (idx >= IDX_CTRL) && (idx <= IDX_LAST) &&
		!idx[0];
	wire logic wr = i_apb.psel && i_apb.penable && i_apb.pwrite && hit;
	wire logic sel_ctrl = (idx == IDX_CTRL);
	wire logic sel_data = (idx == IDX_DATA);
	wire logic sel_lat = (idx == IDX_LAT);
	wire logic sel_ie = (idx == IDX_IE);
	wire logic [31:0] wd = i_apb.pwdata;
	assign o_apb = {1'b1, i_apb.psel && i_apb.penable && !hit, rdata};

	// fifo write path, dropped while in reset or powering up
	wire logic ram_ready = (pwr_cnt == 4'h0) && !ctrl.frst;
	wire logic push_req = wr && sel_data && i_apb.pstrb[1];
	wire logic push_ok = push_req && ram_ready;
	wire logic push = push_ok && !fifo_full;
	wire logic over_ev = push_ok && fifo_full;
	wire fifo_entry_t wr_entry = {wd[D_END], wd[D_BYTE_LSB +: 8]};

	// live status
	wire logic avail = free_bytes > {1'b0, ctrl.thr, 3'b000};
	wire logic [5:0] groups = free_bytes[8:3];
	wire logic [15:0] status = {2'b00, groups, 5'b00000, fifo_full,
		fifo_empty, avail};
	wire logic [15:0] ctrl_img = {3'b000, ctrl.thr, 1'b0, ctrl.psd, ctrl.fei,
		ctrl.fill, ctrl.rev, ctrl.inv, ctrl.fcs_dis, ctrl.frst};

	// read mux; data register always reads zero
	wire logic [15:0] rd_mux = sel_ctrl ? ctrl_img :
		(idx == IDX_STAT) ? status :
		sel_lat ? {10'h000, lat} :
		sel_ie ? {10'h000, ie} : 16'h0000;

	// serial engine decode
	wire logic stuff_now = (ones == ONES_LIMIT);
	wire logic stuffed_st = (state == ST_DATA) || (state == ST_FCS0) ||
		(state == ST_FCS1);
	wire logic raw_bit = stuff_now ? 1'b0 : shift[0];
	wire logic step = i_bit_req && !stuff_now;
	wire logic load = step && (bitcnt == 3'h7);
	wire logic halt = ctrl.frst && (state != ST_FILL);
	wire logic start_ok = !fifo_empty && !ctrl.psd && ram_ready;
	wire logic [15:0] fcs_word = ctrl.fei ? crc_step : ~crc_step;
	wire logic [7:0] fill_byte = ctrl.fill ? ONES_BYTE : FLAG_BYTE;
	wire logic [7:0] data_byte = ctrl.rev ? rev_byte : fifo_rd.data;
	wire logic pop = load && pop_sel && !halt;
	wire logic pend_ev = pop && fifo_rd.last;
	wire logic under_ev = load && under_sel && !halt;

	// bit reversal for msb-first order
	for (genvar i = 0; i < 8; i++) begin : g_rev
		assign rev_byte[i] = fifo_rd.data[7 - i];
	end

	// events into the latched register
	wire logic rel_ev = frst_q && !ctrl.frst;
	wire logic [5:0] ev = {over_ev, under_ev, pend_ev, 1'b0,
		(fifo_empty && !empty_q) || rel_ev, (avail && !avail_q) || rel_ev};
	wire logic [5:0] clr = (wr && sel_lat) ? wd[5:0] : 6'h00;

	assign o_tx_bit = tx_bit;
	assign o_ram_power_down = ctrl.frst;
	assign o_irq = |(lat & ie);

	hdlc_tx_fifo u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_clear(ctrl.frst),
		.i_push(push),
		.i_wr(wr_entry),
		.i_pop(pop),
		.o_rd(fifo_rd),
		.o_empty(fifo_empty),
		.o_full(fifo_full),
		.o_free(free_bytes)
	);

	hdlc_tx_crc16 u_crc (
		.i_crc(crc),
		.i_bit(shift[0]),
		.o_crc(crc_step)
	);

	// what the next byte is, decided at each byte boundary
	always_comb begin
		next_state = ST_FILL;
		next_byte = fill_byte;
		pop_sel = 1'b0;
		under_sel = 1'b0;
		case (state)
		ST_FILL, ST_CLOSE: begin
			if (start_ok) begin
				next_state = ST_OPEN;
				next_byte = FLAG_BYTE;
			end
		end
		ST_OPEN, ST_DATA: begin
			if (state == ST_DATA && cur_last) begin
				next_state = ctrl.fcs_dis ? ST_CLOSE : ST_FCS0;
				next_byte = ctrl.fcs_dis ? FLAG_BYTE : fcs_word[7:0];
			end else if (fifo_empty) begin
				// underflow closes the frame early, receiver sees a bad fcs
				next_state = ST_CLOSE;
				next_byte = FLAG_BYTE;
				under_sel = 1'b1;
			end else begin
				next_state = ST_DATA;
				next_byte = data_byte;
				pop_sel = 1'b1;
			end
		end
		ST_FCS0: begin
			next_state = ST_FCS1;
			next_byte = fcs_hi;
		end
		ST_FCS1: begin
			next_state = ST_CLOSE;
			next_byte = FLAG_BYTE;
		end
		default: begin
			next_state = ST_FILL;
			next_byte = FLAG_BYTE;
		end
		endcase
	end

	// control and enable registers
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ctrl <= {THR_RESET, 7'h00};
			ie <= 6'h00;
		end else begin
			if (wr && sel_ctrl && i_apb.pstrb[1])
				ctrl.thr <= wd[F_THR_LSB +: 5];
			if (wr && sel_ctrl && i_apb.pstrb[0]) begin
				ctrl.psd <= wd[F_PSD];
				ctrl.fei <= wd[F_FEI];
				ctrl.fill <= wd[F_FILL];
				ctrl.rev <= wd[F_REV];
				ctrl.inv <= wd[F_INV];
				ctrl.fcs_dis <= wd[F_FCSDIS];
				ctrl.frst <= wd[F_FRST];
			end
			if (wr && sel_ie)
				ie <= wd[5:0] & LAT_MASK;
		end
	end

	// read data is captured in the setup cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			rdata <= 32'h00000000;
		else if (setup)
			rdata <= {16'h0000, rd_mux};
	end

	// latched status: a set in the clearing cycle wins
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			lat <= 6'h00;
			empty_q <= 1'b1;
			avail_q <= 1'b1;
			frst_q <= 1'b0;
		end else begin
			lat <= ((lat & ~clr) | ev) & LAT_MASK;
			empty_q <= fifo_empty;
			avail_q <= avail;
			frst_q <= ctrl.frst;
		end
	end

	// ram power-up wait after fifo reset release
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			pwr_cnt <= 4'h0;
		else if (ctrl.frst)
			pwr_cnt <= RAM_PWRUP_CYCLES;
		else if (pwr_cnt != 4'h0)
			pwr_cnt <= pwr_cnt - 4'h1;
	end

	// output bit, inverted after framing
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			tx_bit <= 1'b0;
		else if (i_bit_req)
			tx_bit <= raw_bit ^ ctrl.inv;
	end

	// serial engine
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || halt) begin
			state <= ST_FILL;
			shift <= FLAG_BYTE;
			bitcnt <= 3'h0;
			ones <= 3'h0;
			crc <= CRC_INIT;
			fcs_hi <= 8'h00;
			cur_last <= 1'b0;
		end else if (step) begin
			ones <= (stuffed_st && shift[0]) ? ones + 3'h1 : 3'h0;
			if (state == ST_DATA)
				crc <= crc_step;
			if (load) begin
				state <= next_state;
				shift <= next_byte;
				bitcnt <= 3'h0;
				if (pop)
					cur_last <= fifo_rd.last;
				if (next_state == ST_FCS0)
					fcs_hi <= fcs_word[15:8];
				if (next_state == ST_OPEN)
					crc <= CRC_INIT;
			end else begin
				shift <= {1'b0, shift[7:1]};
				bitcnt <= bitcnt + 3'h1;
			end
		end else if (i_bit_req) begin
			ones <= 3'h0; // stuffed zero breaks the run
		end
	end

	avail_rel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		status[S_AVAIL] == (free_bytes >= {1'b0, ctrl.thr, 3'b000} + 9'h001))
		else $error("storage available flag disagrees with threshold");

	start_block_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(ctrl.psd && state == ST_FILL) |=> state != ST_OPEN)
		else $error("frame started while packet start disabled");

	fcs_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(load && !halt && next_state == ST_FCS0) |=>
		shift == ($past(ctrl.fei) ? $past(crc_step[7:0]) : ~$past(crc_step[7:0])))
		else $error("fcs low byte polarity wrong");

	fill_ones_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state == ST_FILL && ctrl.fill && bitcnt == 3'h7 && load && !start_ok)
		|=> shift == ONES_BYTE)
		else $error("ones fill not loaded");

	data_order_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		pop |=> shift[0] == ($past(ctrl.rev) ? $past(fifo_rd.data[7])
		: $past(fifo_rd.data[0])))
		else $error("first data bit in wrong order");

	invert_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_bit_req && stuff_now) |=> o_tx_bit == $past(ctrl.inv))
		else $error("stuffed bit polarity wrong");

	no_fcs_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(load && !halt && state == ST_DATA && cur_last) |=>
		state == ($past(ctrl.fcs_dis) ? ST_CLOSE : ST_FCS0))
		else $error("wrong step after last data byte");

	rst_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		ctrl.frst |=> fifo_empty && state == ST_FILL)
		else $error("fifo reset did not empty and halt");

	pwrup_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$fell(ctrl.frst) |-> !push_ok [*8] ##1 ram_ready)
		else $error("power-up wait length wrong");

	latch_rel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$fell(ctrl.frst) |=> lat[S_EMPTY] && lat[S_AVAIL])
		else $error("latched flags not set at reset release");
endmodule // hdlc_transmit_packet_processor

// ==== src/hdlc_tx_pkg.sv ====
// Purpose: shared constants and carriers of the hdlc transmit processor
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: register indices times four give the byte address
package hdlc_tx_pkg;
	// register indices, byte address is index * 4
	localparam logic [7:0] IDX_CTRL = 8'ha0;
	localparam logic [7:0] IDX_DATA = 8'ha2;
	localparam logic [7:0] IDX_STAT = 8'ha4;
	localparam logic [7:0] IDX_LAT = 8'ha6;
	localparam logic [7:0] IDX_IE = 8'ha8;
	localparam logic [7:0] IDX_LAST = 8'hae;
	// control field positions and reset value
	localparam int F_THR_LSB = 8;
	localparam int F_PSD = 6;
	localparam int F_FEI = 5;
	localparam int F_FILL = 4;
	localparam int F_REV = 3;
	localparam int F_INV = 2;
	localparam int F_FCSDIS = 1;
	localparam int F_FRST = 0;
	localparam logic [4:0] THR_RESET = 5'h10;
	// data register positions
	localparam int D_BYTE_LSB = 8;
	localparam int D_END = 0;
	// status and latched status positions
	localparam int S_AVAIL = 0;
	localparam int S_EMPTY = 1;
	localparam int S_FULL = 2;
	localparam int S_GRP_LSB = 8;
	localparam int L_PEND = 3;
	localparam int L_UNDER = 4;
	localparam int L_OVER = 5;
	localparam logic [5:0] LAT_MASK = 6'h3b;
	// framing constants
	localparam logic [7:0] FLAG_BYTE = 8'h7e;
	localparam logic [7:0] ONES_BYTE = 8'hff;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [2:0] ONES_LIMIT = 3'h5;
	localparam logic [3:0] RAM_PWRUP_CYCLES = 4'h8;
	localparam logic [8:0] FIFO_DEPTH = 9'h100;
	// bus carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;
	// one fifo entry: byte and packet end mark
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} fifo_entry_t;
	// control register image
	typedef struct packed {
		logic [4:0] thr;
		logic psd;
		logic fei;
		logic fill;
		logic rev;
		logic inv;
		logic fcs_dis;
		logic frst;
	} ctrl_t;
endpackage

// ==== src/hdlc_tx_crc16.sv ====
// Purpose: one serial step of the reflected crc-16
// Assumes: lsb-first bit order of the hdlc frame
// Notes: purely combinational
module hdlc_tx_crc16 (
	// state in and bit
	input wire logic [15:0] i_crc,
	input wire logic i_bit,
	// state after the bit
	output logic [15:0] o_crc
);
	import hdlc_tx_pkg::*;
	// feedback decides whether the polynomial folds in
	wire logic fb = i_crc[0] ^ i_bit;
	assign o_crc = {1'b0, i_crc[15:1]} ^ (fb ? CRC_POLY : 16'h0000);
endmodule // hdlc_tx_crc16

// ==== src/hdlc_tx_fifo.sv ====
// Purpose: 256 entry transmit fifo held in flip-flops
// Assumes: caller never pushes when full nor pops when empty
// Notes: clear empties it in one cycle
module hdlc_tx_fifo (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	// write side
	input wire logic i_push,
	input wire hdlc_tx_pkg::fifo_entry_t i_wr,
	// read side
	input wire logic i_pop,
	output hdlc_tx_pkg::fifo_entry_t o_rd,
	// fill state
	output logic o_empty,
	output logic o_full,
	output logic [8:0] o_free
);
	import hdlc_tx_pkg::*;
	fifo_entry_t mem [256];
	logic [7:0] wptr;
	logic [7:0] rptr;
	logic [8:0] count;
	// live flags from the occupancy count
	assign o_empty = (count == 9'h000);
	assign o_full = (count == FIFO_DEPTH);
	assign o_free = FIFO_DEPTH - count;
	assign o_rd = mem[rptr];
	// storage, no reset needed as pointers guard it
	always_ff @(posedge i_ref_clk) begin
		if (i_push)
			mem[wptr] <= i_wr;
	end
	// pointers and count
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || i_clear) begin
			wptr <= 8'h00;
			rptr <= 8'h00;
			count <= 9'h000;
		end else begin
			if (i_push)
				wptr <= wptr + 8'h01;
			if (i_pop)
				rptr <= rptr + 8'h01;
			count <= count + {8'h00, i_push} - {8'h00, i_pop};
		end
	end
endmodule // hdlc_tx_fifo

// ==== verif/framer_channel_model.sv ====
// Purpose: framer overhead channel that asks for and collects bits
// Assumes: one bit slot per request, bit valid the cycle after
// Notes: slow pacing asks every third cycle to stretch the frame
module framer_channel_model (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// pacing
	input wire logic i_slow,
	// serial link
	output logic o_bit_req = 1'b0,
	input wire logic i_tx_bit
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase = 2'h0;
	logic req_d = 1'b0;
	logic rx_q[$];
	// capture one cycle after the slot, when the bit has landed
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			phase <= 2'h0;
			o_bit_req <= 1'b0;
			req_d <= 1'b0;
		end else begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			o_bit_req <= !i_slow || phase == 2'h0;
			req_d <= o_bit_req;
			if (req_d) begin
				rx_q.push_back(i_tx_bit);
			end
		end
	end
endmodule // framer_channel_model

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the hdlc transmit processor
// Assumes: apb master waits for pready, framer model paces bits
// Notes: frames are searched for in the captured serial stream
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import hdlc_tx_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic slow = 1'b0;
	logic bit_req;
	logic tx_bit;
	logic pwr_dn;
	logic irq;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err;
	logic exp_q[$];
	logic [7:0] modes [4] = '{8'h00, 8'h28, 8'h06, 8'h20};

	// 20 MHz reference
	always #25 i_ref_clk = ~i_ref_clk;

	hdlc_transmit_packet_processor dut_u (.i_ref_clk(i_ref_clk),
		.i_rst(i_rst), .i_apb(req), .o_apb(rsp), .i_bit_req(bit_req),
		.o_tx_bit(tx_bit), .o_ram_power_down(pwr_dn), .o_irq(irq));
	framer_channel_model chan_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_slow(slow), .o_bit_req(bit_req), .i_tx_bit(tx_bit));

	// a hung wait must not stall the run forever
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer; extra edge keeps back-to-back drives apart
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= {2'b00, idx, 2'b00};
		req.pwdata <= wd;
		req.pstrb <= 4'hf;
		@(posedge i_ref_clk);
		req.penable <= 1'b1;
		do @(posedge i_ref_clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge i_ref_clk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		xfer(1'b1, idx, wd);
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask

	// expected wire bits: flag, stuffed body and fcs, flag
	task automatic build(input logic [7:0] m, input logic [7:0] b0,
		input logic [7:0] b1);
		logic [15:0] crc;
		logic [7:0] by;
		logic raw[$];
		int ones;
		crc = CRC_INIT;
		ones = 0;
		exp_q = {};
		for (int i = 0; i < 16; i++) begin
			by = (i < 8) ? b0 : b1;
			raw.push_back(m[F_REV] ? by[7 - i % 8] : by[i % 8]);
			crc = (crc >> 1) ^ ((crc[0] ^ raw[i]) ? CRC_POLY : 16'h0000);
		end
		crc = m[F_FEI] ? crc : ~crc;
		for (int i = 0; i < 16 && !m[F_FCSDIS]; i++)
			raw.push_back(crc[i]);
		for (int i = 0; i < 8; i++)
			exp_q.push_back(FLAG_BYTE[i]);
		foreach (raw[i]) begin
			exp_q.push_back(raw[i]);
			ones = raw[i] ? ones + 1 : 0;
			if (ones == 5) begin
				exp_q.push_back(1'b0);
				ones = 0;
			end
		end
		for (int i = 0; i < 8; i++)
			exp_q.push_back(FLAG_BYTE[i]);
		foreach (exp_q[i])
			exp_q[i] = exp_q[i] ^ m[F_INV];
	endtask

	function automatic logic found();
		logic hit;
		found = 1'b0;
		for (int s = 0; s + exp_q.size() <= chan_u.rx_q.size(); s++) begin
			hit = 1'b1;
			foreach (exp_q[i])
				if (chan_u.rx_q[s + i] !== exp_q[i]) hit = 1'b0;
			if (hit) found = 1'b1;
		end
	endfunction

	// main sequence
	initial begin
		repeat (16) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		rchk(IDX_CTRL, 32'h1000);
		rchk(IDX_STAT, 32'h2003);
		rchk(IDX_DATA, 32'h0);
		rchk(8'haa, 32'h0);
		xfer(1'b0, 8'ha9, 32'h0);
		chk(err, 32'h1);
		$display("test registers done");
		// fill past full with starts held off
		wr(IDX_LAT, 32'h3b);
		wr(IDX_CTRL, 32'h1f40);
		for (int i = 0; i < 257; i++) begin
			wr(IDX_DATA, {16'h0, i[7:0], 8'h00});
			if (i == 6) rchk(IDX_STAT, 32'h1f01);
			if (i == 7) rchk(IDX_STAT, 32'h1f00);
		end
		rchk(IDX_STAT, 32'h0004);
		rchk(IDX_LAT, 32'h0020);
		$display("test threshold done");
		// fifo reset drops writes, power-up drops the next ones
		wr(IDX_CTRL, 32'h1041);
		wr(IDX_LAT, 32'h3b);
		chk(pwr_dn, 32'h1);
		wr(IDX_DATA, 32'hab01);
		rchk(IDX_STAT, 32'h2003);
		wr(IDX_CTRL, 32'h1040);
		wr(IDX_DATA, 32'hab00);
		rchk(IDX_STAT, 32'h2003);
		rchk(IDX_LAT, 32'h0003);
		chk(pwr_dn, 32'h0);
		repeat (RAM_PWRUP_CYCLES) @(posedge i_ref_clk);
		wr(IDX_DATA, 32'hab00);
		rchk(IDX_STAT, 32'h1f01);
		wr(IDX_CTRL, 32'h1041);
		wr(IDX_CTRL, 32'h1040);
		repeat (RAM_PWRUP_CYCLES) @(posedge i_ref_clk);
		$display("test fifo reset done");
		// one frame per mode, held until start is enabled
		for (int k = 0; k < 4; k++) begin
			slow <= (k == 3);
			wr(IDX_CTRL, {16'h0, 8'h10, modes[k] | 8'h40});
			wr(IDX_DATA, 32'hf800);
			wr(IDX_DATA, 32'h3f01);
			repeat (60) @(posedge i_ref_clk);
			rchk(IDX_STAT, 32'h1f01);
			wr(IDX_LAT, 32'h3b);
			wr(IDX_IE, 32'h02);
			chan_u.rx_q.delete();
			wr(IDX_CTRL, {16'h0, 8'h10, modes[k]});
			for (int t = 0; t < 2000 && irq !== 1'b1; t++)
				@(posedge i_ref_clk);
			repeat (150) @(posedge i_ref_clk);
			build(modes[k], 8'hf8, 8'h3f);
			chk(found(), 32'h1);
			rchk(IDX_LAT, 32'h000a);
			chk(irq, 32'h1);
			wr(IDX_IE, 32'h0);
			chk(irq, 32'h0);
			wr(IDX_IE, 32'h02);
			wr(IDX_LAT, 32'h02);
			chk(irq, 32'h0);
		end
		$display("test frames done");
		// ones fill between frames
		slow <= 1'b0;
		wr(IDX_CTRL, 32'h1010);
		repeat (20) @(posedge i_ref_clk);
		chan_u.rx_q.delete();
		repeat (30) @(posedge i_ref_clk);
		foreach (chan_u.rx_q[i])
			chk(chan_u.rx_q[i], 32'h1);
		$display("test fill done");
		complete_run();
	end
endmodule // tb_top
